// ---- testbench/front_model.sv ----
`timescale 1ns/1ns
module front_model (
  // Clock
  input wire logic     aclk,
  // Comparator levels and lockout pulse
  output logic         start_trig,
  output logic         stop_trig,
  output logic         ext_lockout,
  // Trigger levels in millivolts
  output logic [15:0]  start_level_mv,
  output logic [15:0]  stop_level_mv
);
  initial begin
    start_trig = 1'b0;
    stop_trig = 1'b0;
    ext_lockout = 1'b0;
  end
  // Level controls stay put during a run
  assign start_level_mv = 16'h04D2;
  assign stop_level_mv = 16'h0ABC;

  // Lines move just after an edge so the sampling edge never races them
  task automatic set(input int w, input logic v);
    @(posedge aclk);
    if (w == 0) start_trig <= v;
    else if (w == 1) stop_trig <= v;
    else ext_lockout <= v;
  endtask

  task automatic pulse(input int w, input int len);
    set(w, 1'b1);
    repeat (len - 1) @(posedge aclk);
    set(w, 1'b0);
  endtask
endmodule

// ---- testbench/interval_props.sv ----
`timescale 1ns/1ns
module interval_props (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Front end inputs
  input wire logic                    start_trig,
  input wire logic                    stop_trig,
  input wire logic [15:0]             start_level_mv,
  input wire logic [15:0]             stop_level_mv,
  // Panel and marker outputs
  input interval_pkg::chan_out_t      start_out,
  input interval_pkg::chan_out_t      stop_out,
  input wire logic                    gate_marker,
  input wire logic [15:0]             level_display_mv,
  input wire logic                    level_is_stop
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sq_start;
    start_out.square_n == !$past(start_trig, 3);
  endproperty
  a_sq_start: assert property (p_sq_start)
    else $error("start square");
  property p_sq_stop;
    stop_out.square_n == !$past(stop_trig, 3);
  endproperty
  a_sq_stop: assert property (p_sq_stop) else $error("stop square");
  property p_dot_width;
    $rose(start_out.dot) |-> start_out.dot [*3] ##1 !start_out.dot;
  endproperty
  a_dot_width: assert property (p_dot_width)
    else $error("dot width");
  property p_dot_start;
    $rose(start_trig) |-> ##[2:6] $rose(start_out.dot);
  endproperty
  a_dot_start: assert property (p_dot_start)
    else $error("start dot");
  property p_dot_stop;
    $rose(stop_trig) |-> ##[2:6] $rose(stop_out.dot);
  endproperty
  a_dot_stop: assert property (p_dot_stop) else $error("stop dot");
  property p_gate_open;
    $rose(gate_marker) |-> start_out.dot || $past(start_out.dot);
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("gate open");
  property p_gate_close;
    $fell(gate_marker) |-> stop_out.dot || $past(stop_out.dot);
  endproperty
  a_gate_close: assert property (p_gate_close)
    else $error("gate end");
  property p_lamp;
    $rose(start_out.dot) |-> ##[0:20] start_out.lamp;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not lit");
  // Reset clears the display, so the first loaded cycle is skipped
  property p_level;
    $past(aresetn) && $stable(level_is_stop) |-> level_display_mv ==
      (level_is_stop ? $past(stop_level_mv) : $past(start_level_mv));
  endproperty
  a_level: assert property (p_level) else $error("level shown");
  c_gate: cover property ($rose(gate_marker));
  c_lamp: cover property ($rose(stop_out.lamp));
  c_sel: cover property ($rose(level_is_stop));
endmodule

bind interval_gate_indicators interval_props props_u (
  .aclk(aclk), .aresetn(aresetn), .start_trig(start_trig),
  .stop_trig(stop_trig), .start_level_mv(start_level_mv),
  .stop_level_mv(stop_level_mv), .start_out(start_out),
  .stop_out(stop_out), .gate_marker(gate_marker),
  .level_display_mv(level_display_mv), .level_is_stop(level_is_stop));

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(n, e, s) chk(n, e, s)
module tb_top;
  // ==========================================================
  // Signals
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, gate_marker, level_is_stop;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        start_trig, stop_trig, ext_lockout;
  logic [15:0] start_level_mv, stop_level_mv, level_display_mv;
  interval_pkg::chan_out_t start_out, stop_out;
  int          fails = 0, checked = 0;

  always #20 aclk = ~aclk;

  front_model fm_u (.aclk(aclk), .start_trig(start_trig),
    .stop_trig(stop_trig), .ext_lockout(ext_lockout),
    .start_level_mv(start_level_mv), .stop_level_mv(stop_level_mv));

  // Short lamp and blink counts keep the run brief
  interval_gate_indicators #(.LAMP_HOLD_CYCLES(20), .BLINK_CYCLES(16))
  dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .start_trig(start_trig),
    .stop_trig(stop_trig), .ext_lockout(ext_lockout),
    .start_level_mv(start_level_mv), .stop_level_mv(stop_level_mv),
    .start_out(start_out), .stop_out(stop_out),
    .gate_marker(gate_marker), .level_display_mv(level_display_mv),
    .level_is_stop(level_is_stop));

  // ==========================================================
  // Tasks
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", interval_pkg::RESP_OKAY, s_axi_bresp);
    if (n == 50) fails++;
    if (n == 50) finish_test;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) fails++;
    if (n == 50) finish_test;
  endtask

  // Start at e, optional second start and early stop at e+x, stop at e+d
  task automatic meas(input int d, input int x);
    int n;
    fm_u.pulse(0, 4);
    if (x > 0) begin
      repeat (x - 5) @(posedge aclk);
      fork
        fm_u.pulse(0, 4);
        fm_u.pulse(1, 4);
      join
    end
    repeat (d - x - 5) @(posedge aclk);
    fm_u.pulse(1, 4);
    for (n = 0; n < 40 && gate_marker !== 1'b0; n++) @(posedge aclk);
    if (n == 40) begin
      fails++;
      finish_test;
    end
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axi_rd(8'(4 * i));
      `CHK("reset value", 32'h0000_0000, rd);
    end
    axi_rd(8'h1C);
    `CHK("unmapped resp", interval_pkg::RESP_SLVERR, resp);
    meas(20, 0);
    axi_rd(interval_pkg::ADDR_COUNT);
    `CHK("count unarmed", 32'h0000_0000, rd);
    axi_wr(interval_pkg::ADDR_CTRL, 32'h0000_0001);
    meas(40, 0);
    axi_rd(interval_pkg::ADDR_RESULT);
    `CHK("result", 32'h0000_0028, rd);
    axi_rd(interval_pkg::ADDR_STATUS);
    `CHK("valid", 1'b1, rd[0]);
    axi_wr(interval_pkg::ADDR_LOCKOUT, 32'h0000_001E);
    axi_wr(interval_pkg::ADDR_CTRL, 32'h0000_0003);
    meas(50, 10);
    axi_rd(interval_pkg::ADDR_RESULT);
    `CHK("lockout result", 32'h0000_0032, rd);
    axi_wr(interval_pkg::ADDR_CTRL, 32'h0000_0007);
    fork
      fm_u.pulse(2, 32);
      meas(60, 10);
    join
    axi_rd(interval_pkg::ADDR_RESULT);
    `CHK("ext result", 32'h0000_003C, rd);
    axi_wr(interval_pkg::ADDR_DEADTIME, 32'h0000_0028);
    axi_wr(interval_pkg::ADDR_CTRL, 32'h0000_0001);
    meas(30, 0);
    meas(30, 0);
    axi_rd(interval_pkg::ADDR_COUNT);
    `CHK("count dead", 32'h0000_0004, rd);
    fm_u.pulse(1, 4);
    repeat (5) @(posedge aclk);
    `CHK("lamp on", 1'b1, stop_out.lamp);
    repeat (30) @(posedge aclk);
    `CHK("lamp off", 1'b0, stop_out.lamp);
    axi_wr(interval_pkg::ADDR_CTRL, 32'h0000_0008);
    fm_u.set(1, 1'b1);
    repeat (14) @(posedge aclk);
    `CHK("blink dark", 1'b0, stop_out.lamp);
    repeat (46) @(posedge aclk);
    `CHK("lamp level", 1'b1, stop_out.lamp);
    fm_u.set(1, 1'b0);
    repeat (60) @(posedge aclk);
    `CHK("lamp low", 1'b0, stop_out.lamp);
    axi_wr(interval_pkg::ADDR_CTRL, 32'h0000_0010);
    axi_rd(interval_pkg::ADDR_LEVEL);
    `CHK("level reg", 32'h0000_0ABC, rd);
    `CHK("level sel", 1'b1, level_is_stop);
    finish_test;
  end
endmodule

// ---- verilog/interval_gate_indicators.sv ----
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module interval_gate_indicators #(
  parameter int unsigned LAMP_HOLD_CYCLES = interval_pkg::LAMP_HOLD_CYCLES,
  parameter int unsigned BLINK_CYCLES     = interval_pkg::BLINK_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Comparator outputs and external lockout, asynchronous
  input  wire logic        start_trig,
  input  wire logic        stop_trig,
  input  wire logic        ext_lockout,
  // Trigger levels in millivolts from the level converter
  input  wire logic [15:0] start_level_mv,
  input  wire logic [15:0] stop_level_mv,
  // Front panel and marker outputs
  output interval_pkg::chan_out_t start_out,
  output interval_pkg::chan_out_t stop_out,
  output logic             gate_marker,
  output logic [15:0]      level_display_mv,
  output logic             level_is_stop
);

  // ==========================================================
  // Constants sized for their counters
  localparam int unsigned LW = interval_pkg::LAMP_W;
  localparam int unsigned DW = interval_pkg::DOT_W;
  localparam logic [LW-1:0] HOLD_LOAD  = LW'(LAMP_HOLD_CYCLES);
  localparam logic [LW-1:0] BLINK_LOAD = LW'(BLINK_CYCLES);
  localparam logic [LW-1:0] BLINK_HALF = LW'(BLINK_CYCLES / 2);
  localparam logic [DW-1:0] DOT_LOAD   = DW'(interval_pkg::DOT_CYCLES);

  // ==========================================================
  // Shared decode
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      interval_pkg::ADDR_CTRL,
      interval_pkg::ADDR_LOCKOUT,
      interval_pkg::ADDR_DEADTIME,
      interval_pkg::ADDR_STATUS,
      interval_pkg::ADDR_RESULT,
      interval_pkg::ADDR_LEVEL,
      interval_pkg::ADDR_COUNT: addr_mapped = 1'b1;
      default:                  addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    merge_strb = res;
  endfunction

  // ==========================================================
  // Registers and state
  interval_pkg::ctrl_t       ctrl_reg;
  logic [31:0]               lockout_reg;
  logic [31:0]               deadtime_reg;
  logic                      valid_reg;
  logic [31:0]               result_reg;
  logic [31:0]               meas_count_reg;
  interval_pkg::gate_state_t state_reg;
  interval_pkg::gate_state_t state_next;
  logic [31:0]               lock_cnt_reg;
  logic [31:0]               dead_cnt_reg;
  logic [31:0]               span_cnt_reg;
  logic                      gate_marker_reg;
  logic [15:0]               level_reg;
  logic                      level_sel_reg;

  // Bus holding registers
  logic        aw_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // Synchronisers: index 0 start, 1 stop, 2 external lockout
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [1:0] prev_reg;
  logic [1:0] trig_event;
  logic       ext_lock;

  logic do_write;
  logic start_ev;
  logic stop_ev;
  logic stop_allowed;
  logic close_ev;
  logic clear_valid;
  logic [1:0] lamp_vec;
  logic [1:0] dot_vec;
  logic [1:0] sq_vec;

  // ==========================================================
  // Input synchronisation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 2'h0;
    end else begin
      meta_reg <= {ext_lockout, stop_trig, start_trig};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg[1:0];
    end
  end

  // Edges of the clean levels, so gating lands on clock edges
  assign trig_event = sync_reg[1:0] & ~prev_reg;
  assign ext_lock   = sync_reg[2];
  assign start_ev   = trig_event[0];
  assign stop_ev    = trig_event[1];

  // ==========================================================
  // Per-channel lamps and markers
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [DW-1:0] dot_cnt_reg;
    logic [LW-1:0] hold_cnt_reg;
    logic [LW-1:0] blink_cnt_reg;
    logic          pend_reg;
    logic          lamp_reg;
    logic          sq_reg;
    logic          lamp3;

    // Dots come straight from trigger edges, not from the gate
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        dot_cnt_reg <= '0;
      end else if (trig_event[ch]) begin
        dot_cnt_reg <= DOT_LOAD;
      end else if (dot_cnt_reg != '0) begin
        dot_cnt_reg <= dot_cnt_reg - 1'b1;
      end
    end

    // Two-state stretcher; retriggers faster than 50 Hz look steady
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hold_cnt_reg <= '0;
      end else if (trig_event[ch]) begin
        hold_cnt_reg <= HOLD_LOAD;
      end else if (hold_cnt_reg != '0) begin
        hold_cnt_reg <= hold_cnt_reg - 1'b1;
      end
    end

    // Three-state blinker: one period per trigger; triggers during a blink queue a single extra period
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        blink_cnt_reg <= '0;
        pend_reg      <= 1'b0;
      end else if (blink_cnt_reg == '0) begin
        if (trig_event[ch] || pend_reg) begin
          blink_cnt_reg <= BLINK_LOAD;
        end
        pend_reg <= 1'b0;
      end else begin
        blink_cnt_reg <= blink_cnt_reg - 1'b1;
        if (trig_event[ch]) begin
          pend_reg <= 1'b1;
        end
      end
    end

    // Lit in first half of a blink, else show the comparator level
    assign lamp3 = (blink_cnt_reg != '0) ? (blink_cnt_reg > BLINK_HALF)
                                         : sync_reg[ch];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        lamp_reg <= 1'b0;
        sq_reg   <= 1'b1;
      end else begin
        lamp_reg <= ctrl_reg.three_state ? lamp3
                                         : (hold_cnt_reg != '0);
        sq_reg   <= ~sync_reg[ch];
      end
    end

    assign lamp_vec[ch] = lamp_reg;
    assign dot_vec[ch]  = dot_cnt_reg != '0;
    assign sq_vec[ch]   = sq_reg;
  end

  // Dot width is a multiple of 40 ns, so 100 ns rounds up to 120 ns
  assign start_out = '{lamp: lamp_vec[0], dot: dot_vec[0],
                       square_n: sq_vec[0]};
  assign stop_out  = '{lamp: lamp_vec[1], dot: dot_vec[1],
                       square_n: sq_vec[1]};

  // ==========================================================
  // Measurement gate
  always_comb begin
    if (!ctrl_reg.lock_en) begin
      stop_allowed = 1'b1;
    end else if (ctrl_reg.lock_ext) begin
      stop_allowed = !ext_lock;
    end else begin
      stop_allowed = lock_cnt_reg == 32'h0000_0000;
    end
  end

  assign close_ev = (state_reg == interval_pkg::GS_OPEN) && stop_ev
                    && stop_allowed;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      interval_pkg::GS_IDLE: begin
        if (ctrl_reg.arm) begin
          state_next = interval_pkg::GS_ARMED;
        end
      end
      interval_pkg::GS_ARMED: begin
        if (!ctrl_reg.arm) begin
          state_next = interval_pkg::GS_IDLE;
        end else if (start_ev) begin
          state_next = interval_pkg::GS_OPEN;
        end
      end
      interval_pkg::GS_OPEN: begin
        if (close_ev) begin
          state_next = interval_pkg::GS_DEAD;
        end else if (!ctrl_reg.arm) begin
          state_next = interval_pkg::GS_IDLE;
        end
      end
      interval_pkg::GS_DEAD: begin
        if (dead_cnt_reg == 32'h0000_0000) begin
          state_next = interval_pkg::GS_HOLD;
        end
      end
      interval_pkg::GS_HOLD: begin
        // Wait for the start level to fall so a held start cannot rearm
        if (!sync_reg[0]) begin
          state_next = ctrl_reg.arm ? interval_pkg::GS_ARMED
                                    : interval_pkg::GS_IDLE;
        end
      end
      default: state_next = interval_pkg::GS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= interval_pkg::GS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Lockout counter loads on the accepted start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == interval_pkg::GS_ARMED && start_ev) begin
      lock_cnt_reg <= lockout_reg;
    end else if (lock_cnt_reg != 32'h0000_0000) begin
      lock_cnt_reg <= lock_cnt_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dead_cnt_reg <= 32'h0000_0000;
    end else if (close_ev) begin
      dead_cnt_reg <= deadtime_reg;
    end else if (dead_cnt_reg != 32'h0000_0000) begin
      dead_cnt_reg <= dead_cnt_reg - 32'h0000_0001;
    end
  end

  // Whole clock periods only; saturates at 32'hFFFF_FFFF, where the result span_cnt_reg + 1 wraps to 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      span_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == interval_pkg::GS_ARMED) begin
      span_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == interval_pkg::GS_OPEN &&
                 span_cnt_reg != 32'hFFFF_FFFF) begin
      span_cnt_reg <= span_cnt_reg + 32'h0000_0001;
    end
  end

  // Result and tally change only on a closed start-stop pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg     <= 32'h0000_0000;
      meas_count_reg <= 32'h0000_0000;
    end else if (close_ev) begin
      result_reg     <= span_cnt_reg + 32'h0000_0001;
      meas_count_reg <= meas_count_reg + 32'h0000_0001;
    end
  end

  // A close in the clearing cycle keeps the flag set
  assign clear_valid = do_write && aw_addr_reg == interval_pkg::ADDR_STATUS
                       && w_strb_reg[0]
                       && w_data_reg[interval_pkg::STAT_VALID_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_reg <= 1'b0;
    end else if (close_ev) begin
      valid_reg <= 1'b1;
    end else if (clear_valid) begin
      valid_reg <= 1'b0;
    end
  end

  // One register stage: fixed 40 ns lag behind the internal gate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_marker_reg <= 1'b0;
    end else begin
      gate_marker_reg <= state_reg ==
                         interval_pkg::GS_OPEN;
    end
  end
  assign gate_marker = gate_marker_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg     <= 16'h0000;
      level_sel_reg <= 1'b0;
    end else begin
      level_reg     <= ctrl_reg.read_stop ? stop_level_mv
                                          : start_level_mv;
      level_sel_reg <= ctrl_reg.read_stop;
    end
  end
  assign level_display_mv = level_reg;
  assign level_is_stop    = level_sel_reg;

  // ==========================================================
  // AXI4-Lite write path
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= interval_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= addr_mapped(aw_addr_reg) ? interval_pkg::RESP_OKAY
                                                : interval_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= interval_pkg::CTRL_RESET;
      lockout_reg  <= interval_pkg::LOCKOUT_RESET;
      deadtime_reg <= interval_pkg::DEADTIME_RESET;
    end else if (do_write) begin
      case (aw_addr_reg)
        interval_pkg::ADDR_CTRL: begin
          if (w_strb_reg[0]) begin
            ctrl_reg <= w_data_reg[4:0];
          end
        end
        interval_pkg::ADDR_LOCKOUT: begin
          lockout_reg <= merge_strb(lockout_reg, w_data_reg, w_strb_reg);
        end
        interval_pkg::ADDR_DEADTIME: begin
          deadtime_reg <= merge_strb(deadtime_reg, w_data_reg, w_strb_reg);
        end
        default: begin
        end
      endcase
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ==========================================================
  // AXI4-Lite read path
  logic [31:0] status_word;
  logic [31:0] read_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[interval_pkg::STAT_VALID_BIT]  = valid_reg;
    status_word[interval_pkg::STAT_GATE_BIT]   =
      state_reg == interval_pkg::GS_OPEN;
    status_word[interval_pkg::STAT_ARMED_BIT]  =
      state_reg == interval_pkg::GS_ARMED;
    status_word[interval_pkg::STAT_LOCKED_BIT] =
      state_reg == interval_pkg::GS_OPEN && !stop_allowed;
    status_word[interval_pkg::STAT_DEAD_BIT]   =
      state_reg == interval_pkg::GS_DEAD;
  end

  always_comb begin
    case ({s_axi_araddr[7:2], 2'b00})
      interval_pkg::ADDR_CTRL:     read_word = {27'h000_0000, ctrl_reg};
      interval_pkg::ADDR_LOCKOUT:  read_word = lockout_reg;
      interval_pkg::ADDR_DEADTIME: read_word = deadtime_reg;
      interval_pkg::ADDR_STATUS:   read_word = status_word;
      interval_pkg::ADDR_RESULT:   read_word = result_reg;
      interval_pkg::ADDR_LEVEL:    read_word = {16'h0000, level_reg};
      interval_pkg::ADDR_COUNT:    read_word = meas_count_reg;
      default:                     read_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= interval_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= read_word;
      rresp_reg  <= addr_mapped({s_axi_araddr[7:2], 2'b00})
                    ? interval_pkg::RESP_OKAY : interval_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule

// ---- verilog/interval_pkg.sv ----
package interval_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned DOT_WIDTH_NS     = 100;
  localparam int unsigned DOT_CYCLES       =
    (DOT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LAMP_HOLD_MS     = 20;
  localparam int unsigned LAMP_HOLD_CYCLES =
    LAMP_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_RATE_HZ    = 10;
  localparam int unsigned BLINK_CYCLES     = CLK_HZ / BLINK_RATE_HZ;
  localparam int unsigned GATE_LAG_NS      = CLK_PERIOD_NS;
  localparam int unsigned LAMP_W           = 22;
  localparam int unsigned DOT_W            = 2;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_LOCKOUT  = 8'h04;
  localparam logic [7:0] ADDR_DEADTIME = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_RESULT   = 8'h10;
  localparam logic [7:0] ADDR_LEVEL    = 8'h14;
  localparam logic [7:0] ADDR_COUNT    = 8'h18;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned STAT_VALID_BIT  = 0;
  localparam int unsigned STAT_GATE_BIT   = 1;
  localparam int unsigned STAT_ARMED_BIT  = 2;
  localparam int unsigned STAT_LOCKED_BIT = 3;
  localparam int unsigned STAT_DEAD_BIT   = 4;
  localparam logic [4:0]  CTRL_RESET      = 5'h00;
  localparam logic [31:0] LOCKOUT_RESET   = 32'h0000_0000;
  localparam logic [31:0] DEADTIME_RESET  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Control word, bit 0 is arm
  typedef struct packed {
    logic read_stop;
    logic three_state;
    logic lock_ext;
    logic lock_en;
    logic arm;
  } ctrl_t;

  // Per-channel front panel outputs
  typedef struct packed {
    logic lamp;
    logic dot;
    logic square_n;
  } chan_out_t;

  typedef enum logic [4:0] {
    GS_IDLE  = 5'b00001,
    GS_ARMED = 5'b00010,
    GS_OPEN  = 5'b00100,
    GS_DEAD  = 5'b01000,
    GS_HOLD  = 5'b10000
  } gate_state_t;

endpackage
